// ==== hw/digital_if_processor_consts.svh ====
// constants of the digital if processor: widths, sizes, timing counts
`ifndef DIGITAL_IF_PROCESSOR_CONSTS_SVH
`define DIGITAL_IF_PROCESSOR_CONSTS_SVH
`define DIGITAL_IF_PROCESSOR_ADC_W        14
`define DIGITAL_IF_PROCESSOR_IQ_W         16
`define DIGITAL_IF_PROCESSOR_PWR_W        32
`define DIGITAL_IF_PROCESSOR_NBIN         4
`define DIGITAL_IF_PROCESSOR_ACQ_WORDS    16
`define DIGITAL_IF_PROCESSOR_ACQ_AW       4
`define DIGITAL_IF_PROCESSOR_BLK_W        2
`define DIGITAL_IF_PROCESSOR_HIT_W        4
`define DIGITAL_IF_PROCESSOR_HIT_MAX      4'hf
`define DIGITAL_IF_PROCESSOR_SPAN_MAX     3'h4
`define DIGITAL_IF_PROCESSOR_CLK_HZ       100000000
`define DIGITAL_IF_PROCESSOR_DENS_RATE    50000
`define DIGITAL_IF_PROCESSOR_DENS_MAX_CYC (`DIGITAL_IF_PROCESSOR_CLK_HZ / `DIGITAL_IF_PROCESSOR_DENS_RATE)
`define DIGITAL_IF_PROCESSOR_FRAME_CYC    (`DIGITAL_IF_PROCESSOR_NBIN * (2 << `DIGITAL_IF_PROCESSOR_SPAN_MAX))
`endif

// ==== hw/digital_if_processor_pkg.sv ====
// types of the digital if processor
`include "digital_if_processor_consts.svh"
package digital_if_processor_pkg;
    typedef enum logic {DIGITAL_IF_PROCESSOR_TRIG_POWER = 1'b0, DIGITAL_IF_PROCESSOR_TRIG_MASK = 1'b1}
        digital_if_processor_trig_mode_t;
    typedef enum logic [1:0] {DIGITAL_IF_PROCESSOR_MV_IDLE = 2'h0, DIGITAL_IF_PROCESSOR_MV_XFER = 2'h1,
                              DIGITAL_IF_PROCESSOR_MV_TAIL = 2'h3} digital_if_processor_mv_t;
    typedef logic signed [`DIGITAL_IF_PROCESSOR_IQ_W-1:0] digital_if_processor_iq_t;
    typedef logic [`DIGITAL_IF_PROCESSOR_PWR_W-1:0]       digital_if_processor_pwr_t;
    typedef struct packed {
        logic [1:0]                               ph;
        logic signed [20:0]                       acc_i;
        logic signed [20:0]                       acc_q;
        logic [4:0]                               dcnt;
        digital_if_processor_iq_t                                 fi;
        digital_if_processor_iq_t                                 fq;
        logic                                     fv;
        digital_if_processor_iq_t [`DIGITAL_IF_PROCESSOR_NBIN-1:0]                wi;
        digital_if_processor_iq_t [`DIGITAL_IF_PROCESSOR_NBIN-1:0]                wq;
        logic [1:0]                               fidx;
        logic                                     odd;
        digital_if_processor_iq_t [1:0][`DIGITAL_IF_PROCESSOR_NBIN-1:0]           xr;
        digital_if_processor_iq_t [1:0][`DIGITAL_IF_PROCESSOR_NBIN-1:0]           xi;
        logic [1:0]                               xv;
        digital_if_processor_pwr_t [`DIGITAL_IF_PROCESSOR_NBIN-1:0]               pw;
        logic                                     pwv;
        digital_if_processor_pwr_t                                tp;
        logic                                     tpv;
        logic                                     trig;
        logic                                     ext_d;
        logic [`DIGITAL_IF_PROCESSOR_ACQ_AW:0]                    wptr;
        logic [2*`DIGITAL_IF_PROCESSOR_ACQ_WORDS-1:0][31:0]       sram_in;
        logic [`DIGITAL_IF_PROCESSOR_BLK_W+`DIGITAL_IF_PROCESSOR_ACQ_AW-1:0]      sd_dummy;
        logic [(1<<`DIGITAL_IF_PROCESSOR_BLK_W)*`DIGITAL_IF_PROCESSOR_ACQ_WORDS-1:0][31:0] sdram;
        logic [`DIGITAL_IF_PROCESSOR_ACQ_WORDS-1:0][31:0]         sram_pci;
        digital_if_processor_mv_t                                 mv;
        logic                                     mv_half;
        logic [`DIGITAL_IF_PROCESSOR_ACQ_AW-1:0]                  mv_cnt;
        logic [`DIGITAL_IF_PROCESSOR_BLK_W-1:0]                   blk;
        logic                                     blk_rst;
        logic [15:0][`DIGITAL_IF_PROCESSOR_HIT_W-1:0]             hits;
        digital_if_processor_iq_t                                 oi;
        digital_if_processor_iq_t                                 oq;
        logic                                     ov;
        logic [31:0]                              pci_q;
        logic [1:0]                               colour;
        logic                                     busy;
    } digital_if_processor_state_t;
endpackage

// ==== hw/digital_if_processor_top.sv ====
// digital if processor: iq split, span filter, trigger, acquisition, density
`timescale 1ns/1ns
`default_nettype none
`include "digital_if_processor_consts.svh"
module digital_if_processor_top
    import digital_if_processor_pkg::*;
(
    // clock and reset
    input  wire logic                               ref_clk_in,
    input  wire logic                               rst_in,
    // converter samples, one per clock
    input  wire logic signed [`DIGITAL_IF_PROCESSOR_ADC_W-1:0]      adc_data_in,
    // setup
    input  wire logic [2:0]                         span_sel_in,
    input  wire digital_if_processor_trig_mode_t                    trig_mode_in,
    input  wire logic [`DIGITAL_IF_PROCESSOR_NBIN-1:0][`DIGITAL_IF_PROCESSOR_PWR_W-1:0] mask_in,
    input  wire logic                               ext_trig_in,
    // host side reads
    input  wire logic [`DIGITAL_IF_PROCESSOR_ACQ_AW-1:0]            pci_addr_in,
    input  wire logic [3:0]                         pix_addr_in,
    // results
    output logic signed [`DIGITAL_IF_PROCESSOR_IQ_W-1:0]            iq_i_out,
    output logic signed [`DIGITAL_IF_PROCESSOR_IQ_W-1:0]            iq_q_out,
    output logic                                    iq_valid_out,
    output logic                                    trig_out,
    output logic [31:0]                             pci_data_out,
    output logic [1:0]                              pix_colour_out,
    output logic                                    acq_busy_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic digital_if_processor_pwr_t power(input digital_if_processor_iq_t re, input digital_if_processor_iq_t im);
        logic signed [31:0] pr;
        logic signed [31:0] pi;
        pr = re * re;
        pi = im * im;
        power = digital_if_processor_pwr_t'(pr) + digital_if_processor_pwr_t'(pi);
    endfunction

    // taper of a four-sample frame: ends at half weight
    function automatic digital_if_processor_iq_t window(input digital_if_processor_iq_t x, input logic [1:0] k);
        window = (k == 2'h0 || k == 2'h3) ? (x >>> 1) : x;
    endfunction

    function automatic logic [1:0] row_of(input digital_if_processor_pwr_t p);
        if (|p[31:24]) begin
            row_of = 2'h3;
        end else if (|p[23:16]) begin
            row_of = 2'h2;
        end else if (|p[15:8]) begin
            row_of = 2'h1;
        end else begin
            row_of = 2'h0;
        end
    endfunction

    digital_if_processor_state_t s_ff;
    digital_if_processor_state_t nxt_s;
    logic [2:0]  span;
    logic [4:0]  dlast;
    logic [5:0]  blk_word;
    logic [5:0]  blk_prev;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        // span above the top code is clamped so a frame stays short
        span  = (span_sel_in > `DIGITAL_IF_PROCESSOR_SPAN_MAX) ? `DIGITAL_IF_PROCESSOR_SPAN_MAX : span_sel_in;
        dlast = 5'((2 << span) - 1);
        blk_word = {s_ff.blk, s_ff.mv_cnt};
        blk_prev = {s_ff.blk, 4'(s_ff.mv_cnt - 4'h1)};
        nxt_s.fv   = 1'b0;
        nxt_s.xv   = 2'h0;
        nxt_s.pwv  = 1'b0;
        nxt_s.tpv  = 1'b0;
        nxt_s.trig = 1'b0;
        nxt_s.ext_d = ext_trig_in;

        // quarter-rate mixer and decimating average
        nxt_s.ph = 2'(s_ff.ph + 2'h1);
        case (s_ff.ph)
            2'h0: nxt_s.acc_i = s_ff.acc_i + 21'(adc_data_in);
            2'h1: nxt_s.acc_q = s_ff.acc_q - 21'(adc_data_in);
            2'h2: nxt_s.acc_i = s_ff.acc_i - 21'(adc_data_in);
            default: nxt_s.acc_q = s_ff.acc_q + 21'(adc_data_in);
        endcase
        nxt_s.dcnt = 5'(s_ff.dcnt + 5'h1);
        if (s_ff.dcnt >= dlast) begin
            nxt_s.dcnt  = 5'h0;
            nxt_s.fi    = digital_if_processor_iq_t'(nxt_s.acc_i >>> (span + 3'h1));
            nxt_s.fq    = digital_if_processor_iq_t'(nxt_s.acc_q >>> (span + 3'h1));
            nxt_s.fv    = 1'b1;
            nxt_s.acc_i = '0;
            nxt_s.acc_q = '0;
        end

        // trigger path: power mode straight from the filtered words
        if (s_ff.fv && trig_mode_in == DIGITAL_IF_PROCESSOR_TRIG_POWER) begin
            nxt_s.tp  = power(s_ff.fi, s_ff.fq);
            nxt_s.tpv = 1'b1;
        end
        if (s_ff.tpv && s_ff.tp > mask_in[0]) begin
            nxt_s.trig = 1'b1;
        end

        // framing for transforms, also feeds the density bitmap
        if (s_ff.fv) begin
            nxt_s.wi[s_ff.fidx] = window(s_ff.fi, s_ff.fidx);
            nxt_s.wq[s_ff.fidx] = window(s_ff.fq, s_ff.fidx);
            nxt_s.fidx = 2'(s_ff.fidx + 2'h1);
            if (s_ff.fidx == 2'h3) begin
                nxt_s.odd = ~s_ff.odd;
                nxt_s.xv[s_ff.odd] = 1'b1;
            end
        end
        // transforms: even frames in slot 0, odd frames in slot 1
        for (int p = 0; p < 2; p++) begin
            if (nxt_s.xv[p]) begin
                nxt_s.xr[p][0] = nxt_s.wi[0] + nxt_s.wi[1]
                               + nxt_s.wi[2] + nxt_s.wi[3];
                nxt_s.xi[p][0] = nxt_s.wq[0] + nxt_s.wq[1]
                               + nxt_s.wq[2] + nxt_s.wq[3];
                nxt_s.xr[p][1] = nxt_s.wi[0] - nxt_s.wi[2]
                               + nxt_s.wq[1] - nxt_s.wq[3];
                nxt_s.xi[p][1] = nxt_s.wq[0] - nxt_s.wq[2]
                               - nxt_s.wi[1] + nxt_s.wi[3];
                nxt_s.xr[p][2] = nxt_s.wi[0] - nxt_s.wi[1]
                               + nxt_s.wi[2] - nxt_s.wi[3];
                nxt_s.xi[p][2] = nxt_s.wq[0] - nxt_s.wq[1]
                               + nxt_s.wq[2] - nxt_s.wq[3];
                nxt_s.xr[p][3] = nxt_s.wi[0] - nxt_s.wi[2]
                               - nxt_s.wq[1] + nxt_s.wq[3];
                nxt_s.xi[p][3] = nxt_s.wq[0] - nxt_s.wq[2]
                               + nxt_s.wi[1] - nxt_s.wi[3];
            end
        end
        // power stage, one frame at a time
        if (|s_ff.xv) begin
            for (int k = 0; k < `DIGITAL_IF_PROCESSOR_NBIN; k++) begin
                nxt_s.pw[k] = power(s_ff.xr[s_ff.xv[1]][k],
                                    s_ff.xi[s_ff.xv[1]][k]);
            end
            nxt_s.pwv = 1'b1;
        end
        if (s_ff.pwv) begin
            for (int k = 0; k < `DIGITAL_IF_PROCESSOR_NBIN; k++) begin
                if (trig_mode_in == DIGITAL_IF_PROCESSOR_TRIG_MASK && s_ff.pw[k] > mask_in[k]) begin
                    nxt_s.trig = 1'b1;
                end
                // one frame per at most FRAME_CYC clocks, far under DENS_MAX_CYC
                if (s_ff.hits[{row_of(s_ff.pw[k]), 2'(k)}] != `DIGITAL_IF_PROCESSOR_HIT_MAX) begin
                    nxt_s.hits[{row_of(s_ff.pw[k]), 2'(k)}] = 4'(
                        s_ff.hits[{row_of(s_ff.pw[k]), 2'(k)}] + 4'h1);
                end
            end
        end

        // acquisition: ping-pong input buffer
        if (s_ff.fv) begin
            nxt_s.sram_in[s_ff.wptr] = {s_ff.fi, s_ff.fq};
            nxt_s.wptr = 5'(s_ff.wptr + 5'h1);
            if (s_ff.wptr[3:0] == 4'hf) begin
                nxt_s.mv      = DIGITAL_IF_PROCESSOR_MV_XFER;
                nxt_s.mv_half = s_ff.wptr[4];
                nxt_s.mv_cnt  = 4'h0;
            end
        end
        // mover: sdram block then the pci window, one word behind
        case (s_ff.mv)
            DIGITAL_IF_PROCESSOR_MV_XFER: begin
                nxt_s.sdram[blk_word] = s_ff.sram_in[{s_ff.mv_half, s_ff.mv_cnt}];
                if (s_ff.mv_cnt != 4'h0) begin
                    nxt_s.sram_pci[4'(s_ff.mv_cnt - 4'h1)] =
                        s_ff.sdram[blk_prev];
                end
                nxt_s.mv_cnt = 4'(s_ff.mv_cnt + 4'h1);
                if (s_ff.mv_cnt == 4'hf) begin
                    nxt_s.mv = DIGITAL_IF_PROCESSOR_MV_TAIL;
                end
            end
            DIGITAL_IF_PROCESSOR_MV_TAIL: begin
                // counter has wrapped here, so name the last word outright
                nxt_s.sram_pci[4'hf] = s_ff.sdram[{s_ff.blk, 4'hf}];
                nxt_s.blk = s_ff.blk_rst ? '0 : 2'(s_ff.blk + 2'h1);
                nxt_s.blk_rst = 1'b0;
                if (nxt_s.mv != DIGITAL_IF_PROCESSOR_MV_XFER) begin
                    nxt_s.mv = DIGITAL_IF_PROCESSOR_MV_IDLE;
                end
            end
            default: begin
                if (nxt_s.mv != DIGITAL_IF_PROCESSOR_MV_XFER) begin
                    nxt_s.mv = DIGITAL_IF_PROCESSOR_MV_IDLE;
                end
            end
        endcase
        // external trigger edge is the address timing reference
        if (ext_trig_in && !s_ff.ext_d) begin
            nxt_s.wptr = '0;
            if (s_ff.mv == DIGITAL_IF_PROCESSOR_MV_IDLE) begin
                nxt_s.blk = '0;
            end else begin
                nxt_s.blk_rst = 1'b1;
            end
        end

        // registered outputs
        nxt_s.oi     = s_ff.fi;
        nxt_s.oq     = s_ff.fq;
        nxt_s.ov     = s_ff.fv;
        nxt_s.pci_q  = s_ff.sram_pci[pci_addr_in];
        nxt_s.colour = s_ff.hits[pix_addr_in][3:2];
        nxt_s.busy   = (nxt_s.mv != DIGITAL_IF_PROCESSOR_MV_IDLE);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign iq_i_out       = s_ff.oi;
    assign iq_q_out       = s_ff.oq;
    assign iq_valid_out   = s_ff.ov;
    assign trig_out       = s_ff.trig;
    assign pci_data_out   = s_ff.pci_q;
    assign pix_colour_out = s_ff.colour;
    assign acq_busy_out   = s_ff.busy;
endmodule
`default_nettype wire

// ==== dv/digital_if_processor_top_chk.sv ====
// port-level assertion checker of the digital if processor
`timescale 1ns/1ns
`default_nettype none
module digital_if_processor_top_chk
    import digital_if_processor_pkg::*;
(
    // clock and reset
    input  wire logic            ref_clk_in,
    input  wire logic            rst_in,
    // setup
    input  wire logic [2:0]      span_sel_in,
    input  wire digital_if_processor_trig_mode_t trig_mode_in,
    input  wire logic [3:0]      pix_addr_in,
    // results
    input  wire logic            iq_valid_out,
    input  wire logic            trig_out,
    input  wire logic [1:0]      pix_colour_out,
    input  wire logic            acq_busy_out
);
    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    logic [5:0] gap_ff;
    logic [4:0] busy_ff;
    logic [2:0] sel_ff;
    logic       seen_ff;
    logic [5:0] want;
    // selects above four behave as four
    assign want = (span_sel_in > 3'h4) ? 6'h20 : 6'h02 << span_sel_in;
    always_ff @(posedge ref_clk_in) begin
        sel_ff  <= span_sel_in;
        gap_ff  <= (rst_in || iq_valid_out) ? 6'h00 : gap_ff + 6'h01;
        busy_ff <= (rst_in || !acq_busy_out) ? 5'h00 : busy_ff + 5'h01;
        // gap only trusted once a word came out under the same span
        seen_ff <= !rst_in
                   && (iq_valid_out || (seen_ff && sel_ff == span_sel_in));
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_rst_quiet;
        $fell(rst_in) |-> !trig_out && !iq_valid_out && !acq_busy_out;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs not quiet after reset");
    property p_trig_pulse;
        trig_out |=> !trig_out;
    endproperty
    a_trig_pulse: assert property (p_trig_pulse)
        else $error("trigger longer than one cycle");
    property p_valid_gap;
        iq_valid_out && seen_ff |-> gap_ff == want - 6'h01;
    endproperty
    a_valid_gap: assert property (p_valid_gap)
        else $error("filtered word spacing off");
    property p_pwr_trig;
        trig_out && trig_mode_in == DIGITAL_IF_PROCESSOR_TRIG_POWER |-> $past(iq_valid_out);
    endproperty
    a_pwr_trig: assert property (p_pwr_trig)
        else $error("power trigger not tied to a word");
    property p_mask_trig;
        trig_out && trig_mode_in == DIGITAL_IF_PROCESSOR_TRIG_MASK
            |-> $past(iq_valid_out, 2);
    endproperty
    a_mask_trig: assert property (p_mask_trig)
        else $error("mask trigger not tied to a word");
    property p_busy_start;
        $rose(acq_busy_out) |-> iq_valid_out;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("move started without a word");
    property p_busy_len;
        $fell(acq_busy_out) |-> busy_ff == 5'h11;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("move length not seventeen cycles");
    property p_colour_mono;
        $past(pix_addr_in) == $past(pix_addr_in, 2)
            |-> pix_colour_out >= $past(pix_colour_out);
    endproperty
    a_colour_mono: assert property (p_colour_mono)
        else $error("point colour fell back");
endmodule
bind digital_if_processor_top digital_if_processor_top_chk i_chk (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .span_sel_in(span_sel_in),
    .trig_mode_in(trig_mode_in), .pix_addr_in(pix_addr_in),
    .iq_valid_out(iq_valid_out), .trig_out(trig_out),
    .pix_colour_out(pix_colour_out), .acq_busy_out(acq_busy_out));
`default_nettype wire

// ==== dv/digital_if_processor_adc_model.sv ====
// converter model: one sample per clock, dc level or quarter-rate tone
`timescale 1ns/1ns
`default_nettype none
`include "digital_if_processor_consts.svh"
module digital_if_processor_adc_model (
    // clock and reset
    input  wire logic                          ref_clk_in,
    input  wire logic                          rst_in,
    // waveform choice
    input  wire logic                          tone_in,
    input  wire logic signed [`DIGITAL_IF_PROCESSOR_ADC_W-1:0] amp_in,
    // samples
    output logic signed [`DIGITAL_IF_PROCESSOR_ADC_W-1:0]      adc_data_out
);
    logic [1:0] ph_ff;
    initial adc_data_out = 14'sh0;
    // phase follows the mixer phase on the capturing edge, no reset race
    always @(posedge ref_clk_in) begin
        ph_ff <= rst_in ? 2'h0 : ph_ff + 2'h1;
    end
    // launched off the falling edge so the sample is settled at capture
    always @(negedge ref_clk_in) begin
        case (ph_ff)
            2'h0: adc_data_out <= amp_in;
            2'h2: adc_data_out <= tone_in ? -amp_in : amp_in;
            default: adc_data_out <= tone_in ? 14'sh0 : amp_in;
        endcase
    end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench of the digital if processor
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, want) begin n_compared++; if ((got) !== (want)) begin \
    fails++; $display("MISMATCH t=%0t got %0h want %0h", $time, got, want); \
    end end
module tb_top
    import digital_if_processor_pkg::*;
();
    typedef struct packed {logic tone; logic [2:0] sel; logic [31:0] pw;}
        digital_if_processor_tb_row_t;
    typedef struct packed {logic [1:0] bin; logic [31:0] lim; logic hit;}
        digital_if_processor_tb_mask_t;
    logic             ref_clk_in = 1'b0;
    logic             rst_in = 1'b1;
    wire signed [13:0] adc_data;
    logic [2:0]       span_sel = 3'h1;
    digital_if_processor_trig_mode_t  trig_mode = DIGITAL_IF_PROCESSOR_TRIG_POWER;
    logic [3:0][31:0] mask = '1;
    logic             ext_trig = 1'b0;
    logic [3:0]       pci_addr = 4'h0;
    logic [3:0]       pix_addr = 4'h0;
    logic             tone = 1'b1;
    logic signed [15:0] iq_i;
    logic signed [15:0] iq_q;
    logic             iq_valid;
    logic             trig;
    logic             busy;
    logic [31:0]      pci_data;
    logic [1:0]       colour;
    logic signed [31:0] ei;
    logic signed [31:0] eq;
    int               fails = 0;
    int               n_compared = 0;
    int               cyc = 0;
    int               cnt;
    int               k;
    // amplitude 1000: a tone filters to magnitude 500
    digital_if_processor_tb_row_t  rows [5] = '{{1'b0, 3'h0, 32'h7a120},
        {1'b0, 3'h1, 32'h0}, {1'b1, 3'h1, 32'h3d090},
        {1'b1, 3'h2, 32'h3d090}, {1'b1, 3'h5, 32'h3d090}};
    digital_if_processor_tb_mask_t mrow [6] = '{{2'h0, 32'h22550f, 1'b1},
        {2'h0, 32'h225510, 1'b0}, {2'h1, 32'h1e847, 1'b1},
        {2'h1, 32'h1e848, 1'b0}, {2'h3, 32'h1e847, 1'b1},
        {2'h2, 32'h0, 1'b0}};
    // {point address, colour}
    logic [5:0] pix [6] = '{6'h23, 6'h27, 6'h0b, 6'h00, 6'h30, 6'h14};
    digital_if_processor_adc_model i_adc (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .tone_in(tone), .amp_in(14'sh3e8), .adc_data_out(adc_data));
    digital_if_processor_top i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .adc_data_in(adc_data), .span_sel_in(span_sel),
        .trig_mode_in(trig_mode), .mask_in(mask), .ext_trig_in(ext_trig),
        .pci_addr_in(pci_addr), .pix_addr_in(pix_addr), .iq_i_out(iq_i),
        .iq_q_out(iq_q), .iq_valid_out(iq_valid), .trig_out(trig),
        .pci_data_out(pci_data), .pix_colour_out(colour),
        .acq_busy_out(busy));
    initial forever #5 ref_clk_in = ~ref_clk_in;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 10000) begin
            $display("MISMATCH t=%0t timeout", $time);
            fails++;
            test_done();
        end
    end
    task automatic do_reset();
        rst_in = 1'b1;
        repeat (16) @(negedge ref_clk_in);
        `CHK({trig, iq_valid, busy, colour, pci_data}, 37'h0)
        rst_in = 1'b0;
    endtask
    task automatic wait_sig(input bit use_busy, input logic lvl);
        for (k = 0; k < 200; k++) begin
            @(posedge ref_clk_in);
            #1;
            if ((use_busy ? busy : iq_valid) === lvl) break;
        end
        `CHK(k < 200, 1'b1)
    endtask
    task automatic count_trig(input int n);
        cnt = 0;
        repeat (n) begin
            @(posedge ref_clk_in);
            #1;
            if (trig === 1'b1) cnt++;
        end
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        foreach (rows[n]) begin
            @(negedge ref_clk_in);
            span_sel = rows[n].sel;
            tone = rows[n].tone;
            do_reset();
            repeat (3) wait_sig(1'b0, 1'b1);
            repeat (2) begin
                wait_sig(1'b0, 1'b1);
                ei = iq_i;
                eq = iq_q;
                `CHK(ei * ei + eq * eq, rows[n].pw)
            end
        end
        @(negedge ref_clk_in);
        span_sel = 3'h1;
        mask[0] = 32'h3d08f;
        do_reset();
        count_trig(200);
        `CHK(cnt >= 45, 1'b1)
        @(negedge ref_clk_in);
        mask[0] = 32'h3d090;
        repeat (8) @(negedge ref_clk_in);
        count_trig(200);
        `CHK(cnt, 0)
        @(negedge ref_clk_in);
        trig_mode = DIGITAL_IF_PROCESSOR_TRIG_MASK;
        mask = '1;
        do_reset();
        foreach (mrow[n]) begin
            mask = '1;
            mask[mrow[n].bin] = mrow[n].lim;
            // frames in flight are compared against the new limits
            repeat (24) @(negedge ref_clk_in);
            count_trig(256);
            `CHK(mrow[n].hit ? cnt >= 15 : cnt == 0, 1'b1)
            @(negedge ref_clk_in);
        end
        foreach (pix[n]) begin
            pix_addr = pix[n][5:2];
            repeat (2) @(negedge ref_clk_in);
            `CHK(colour, pix[n][1:0])
        end
        wait_sig(1'b1, 1'b1);
        wait_sig(1'b1, 1'b0);
        for (int a = 0; a < 16; a += 15) begin
            @(negedge ref_clk_in);
            pci_addr = 4'(a);
            @(negedge ref_clk_in);
            ei = $signed(pci_data[31:16]);
            eq = $signed(pci_data[15:0]);
            `CHK(ei * ei + eq * eq, 32'h3d090)
        end
        repeat (5) wait_sig(1'b0, 1'b1);
        @(negedge ref_clk_in);
        ext_trig = 1'b1;
        cnt = 0;
        for (k = 0; k < 200; k++) begin
            @(posedge ref_clk_in);
            #1;
            // the sixteenth word comes out together with the move start
            if (iq_valid === 1'b1) cnt++;
            if (busy === 1'b1) break;
        end
        `CHK(cnt, 16)
        test_done();
    end
endmodule
`default_nettype wire
